// ==== dv/dbd_dual_bus_demux_asserts.sv ====
// checker for the dual bus demux, sees only the top module's ports
// assumes sample domain checks wait until the internal reset is over
`timescale 1ns/10ps
module dbd_dual_bus_demux_asserts (
   // clocks and reset
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   sample_clk,
   // inputs
   input wire logic [7:0]             quant_code,
   input wire logic                   edge_select_pin,
   input wire logic                   power_down_pin,
   // outputs
   input wire dbd_pkg::dbd_word_pair_s out_words,
   input wire logic                   out_bus_oe,
   input wire logic                   out_word_valid,
   input wire dbd_pkg::dbd_fwd_clk_s  out_clk,
   input wire logic                   analog_power_down,
   input wire logic                   internal_reset_active,
   input wire logic                   clock_present
);
   import dbd_pkg::*;
   clk_pair_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      out_clk.neg == !out_clk.pos) else $error("clock pair not complementary");
   code_map_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      $changed(out_words) && out_bus_oe |-> out_words.second == ($past(quant_code) ^ OB_FLIP))
      else $error("even word coding wrong");
   odd_bus_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      $changed(out_words) && out_bus_oe |-> out_words.first == ($past(quant_code, 2) ^ OB_FLIP))
      else $error("odd word on wrong bus");
   half_rate_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      $changed(out_words) && out_bus_oe |=> $stable(out_words)) else $error("bus updated twice in a row");
   clk_toggle_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      out_bus_oe && $past(out_bus_oe) && edge_select_pin == $past(edge_select_pin, 4)
      |-> out_clk.pos != $past(out_clk.pos)) else $error("forwarded clock missed a phase");
   data_edge_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      $changed(out_words) && out_bus_oe && edge_select_pin == $past(edge_select_pin, 4)
      |-> out_clk.pos == edge_select_pin) else $error("data changed on wrong edge");
   pd_float_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      power_down_pin [*4] |-> !out_bus_oe) else $error("bus driven in power down");
   valid_oe_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      out_word_valid |-> out_bus_oe) else $error("valid word on floating bus");
   flush_pairs_a: assert property (@(posedge sample_clk) disable iff (rst || internal_reset_active)
      $rose(out_bus_oe) |-> !out_word_valid [*7]) else $error("stale pair marked valid");
   reset_hold_a: assert property (@(posedge clk) disable iff (rst)
      internal_reset_active |-> analog_power_down) else $error("analog up during reset");
   reset_entry_a: assert property (@(posedge clk) disable iff (rst)
      $past(rst) |-> internal_reset_active && analog_power_down) else $error("reset not active after rst");
   pd_follow_a: assert property (@(posedge clk) disable iff (rst)
      (!internal_reset_active && !power_down_pin) [*4] |-> !analog_power_down) else $error("analog stuck down");
   pair_c: cover property (@(posedge sample_clk) out_word_valid && $changed(out_words));
   pd_c: cover property (@(posedge sample_clk) $fell(out_bus_oe));
   run_c: cover property (@(posedge clk) $fell(internal_reset_active));
endmodule
bind dbd_dual_bus_demux dbd_dual_bus_demux_asserts i_dbd_dual_bus_demux_asserts (
   .clk, .rst, .sample_clk, .quant_code, .edge_select_pin, .power_down_pin, .out_words, .out_bus_oe,
   .out_word_valid, .out_clk, .analog_power_down, .internal_reset_active, .clock_present);

// ==== dv/dbd_rx_model.sv ====
// receiving capture model: latches both buses on the quiet clock edge
// assumes the bench reads and clears stream between scenarios
`timescale 1ns/10ps
module dbd_rx_model (
   // forwarded clock and buses
   input wire dbd_pkg::dbd_fwd_clk_s   out_clk,
   input wire dbd_pkg::dbd_word_pair_s out_words,
   input wire logic                    out_bus_oe,
   input wire logic                    out_word_valid,
   // edge select level on the board
   input wire logic                    edge_select_pin
);
   import dbd_pkg::*;
   // interleaved samples, oldest first
   logic [SAMPLE_W-1:0] stream[$];
   // capture opposite the data edge so both words are settled
   always @(out_clk.pos) begin
      // stale pairs and a floating bus are thrown away
      if (out_clk.pos !== edge_select_pin && out_bus_oe === 1'b1 && out_word_valid === 1'b1) begin
         stream.push_back(out_words.first);
         stream.push_back(out_words.second);
      end
   end
endmodule

// ==== dv/tb_dual_bus_output_demux.sv ====
// self-checking bench for the dual bus demux with a capture model
// assumes an 80 ns sample clock that the bench may stop and restart
`timescale 1ns/10ps
module tb_dual_bus_output_demux;
   import dbd_pkg::*;
   logic clk = 1'b0, rst = 1'b1, sample_clk = 1'b0, sclk_run = 1'b1;
   logic [SAMPLE_W-1:0] quant_code = 8'h00;
   logic                edge_select_pin = 1'b1, power_down_pin = 1'b0;
   dbd_word_pair_s      out_words;
   dbd_fwd_clk_s        out_clk;
   logic                out_bus_oe, out_word_valid, analog_power_down, internal_reset_active, clock_present;
   int                  n_errors = 0, comparisons = 0;
   always #2.5 clk = ~clk;
   // sample clock keeps running between scenarios, phase unrelated to clk
   initial begin #13.3; forever #40 sample_clk = sclk_run ? ~sample_clk : sample_clk; end
   // a rising count stands in for the converter output
   always @(negedge sample_clk) quant_code <= quant_code + 8'h01;
   dbd_dual_bus_demux i_dbd_dual_bus_demux (.clk(clk), .rst(rst), .sample_clk(sample_clk),
      .quant_code(quant_code), .edge_select_pin(edge_select_pin), .power_down_pin(power_down_pin),
      .out_words(out_words), .out_bus_oe(out_bus_oe), .out_word_valid(out_word_valid), .out_clk(out_clk),
      .analog_power_down(analog_power_down), .internal_reset_active(internal_reset_active),
      .clock_present(clock_present));
   dbd_rx_model i_dbd_rx_model (.out_clk(out_clk), .out_words(out_words), .out_bus_oe(out_bus_oe),
      .out_word_valid(out_word_valid), .edge_select_pin(edge_select_pin));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // bounded wait on the internal reset status
   task automatic wait_ira(input logic lvl);
      for (int i = 0; i < 4000 && internal_reset_active !== lvl; i++) @(negedge clk);
      if (internal_reset_active !== lvl) begin
         check(internal_reset_active, lvl, "internal reset wait ran out");
         give_verdict();
      end
   endtask
   // power down, pick an edge, resume and judge the rebuilt stream
   task automatic sc_stream(input logic es);
      logic hit;
      hit = 1'b0;
      @(negedge clk) power_down_pin = 1'b1;
      repeat (8) @(posedge sample_clk);
      #1 check(out_bus_oe, 1'b0, "bus driven in power down");
      check(analog_power_down, 1'b1, "analog up in power down");
      @(negedge clk) edge_select_pin = es;
      power_down_pin = 1'b0;
      i_dbd_rx_model.stream.delete();
      repeat (300) @(posedge sample_clk);
      check(i_dbd_rx_model.stream.size() >= 270, 1'b1, "too few words captured");
      for (int i = 1; i < i_dbd_rx_model.stream.size(); i++)
         check(i_dbd_rx_model.stream[i], 8'(i_dbd_rx_model.stream[i-1] + 8'h01), "stream out of order");
      for (int i = 0; i < 2; i++) begin
         @(posedge sample_clk);
         #1 if (out_words.second === (quant_code ^ OB_FLIP)) begin
            hit = 1'b1;
            check(out_words.first, 8'(quant_code - 8'h01) ^ OB_FLIP, "odd word misplaced");
            check(out_clk.pos, es, "data on wrong clock edge");
         end
      end
      check(hit, 1'b1, "even word not offset binary");
   endtask
   // stopped sample clock holds the last code
   task automatic sc_stop();
      dbd_word_pair_s w;
      @(negedge clk) sclk_run = 1'b0;
      repeat (40) @(negedge clk);
      w = out_words;
      repeat (200) @(negedge clk);
      check(out_words, w, "code lost with clock stopped");
      check(clock_present, 1'b0, "stopped clock still seen");
      sclk_run = 1'b1;
      repeat (100) @(negedge clk);
      check(clock_present, 1'b1, "running clock not seen");
   endtask
   // reset without a sample clock keeps the analog section down
   task automatic sc_noclk_reset();
      @(negedge clk) sclk_run = 1'b0;
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (500) @(negedge clk);
      check(internal_reset_active, 1'b1, "reset ended without clock");
      check(analog_power_down, 1'b1, "analog up without clock");
      sclk_run = 1'b1;
      wait_ira(1'b0);
      repeat (8) @(negedge clk);
      check(analog_power_down, 1'b0, "analog stays down with clock");
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      wait_ira(1'b0);
      sc_stream(1'b1);
      sc_stream(1'b0);
      sc_stop();
      sc_noclk_reset();
      sc_stream(1'b1);
      give_verdict();
   end
   initial begin
      #200000;
      check(1'b0, 1'b1, "run did not finish");
      give_verdict();
   end
endmodule

// ==== rtl/dbd_clk_mon.sv ====
// sample clock presence monitor on the system clock
// assumes alive_s is the synchronised toggle that flips on every sample edge
`timescale 1ns/10ps
module dbd_clk_mon
   import dbd_pkg::*;
(
   // system clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // synchronised sample clock toggle
   input  wire logic alive_s,
   // sample clock seen toggling recently
   output logic      clock_present
);
   dbd_mon_s mon_q;   // registered state
   dbd_mon_s mon_d;   // next state

   // any change of the toggle restarts the loss timer
   always_comb begin
      mon_d      = mon_q;
      mon_d.last = alive_s;
      if (alive_s != mon_q.last) begin
         mon_d.cnt     = '0;
         mon_d.present = 1'b1;
      end else if (mon_q.cnt == LOSS_LAST) begin
         // timer ran out: clock has stopped
         mon_d.present = 1'b0;
      end else begin
         mon_d.cnt = mon_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mon_q <= MON_RST;
      end else begin
         mon_q <= mon_d;
      end
   end

   assign clock_present = mon_q.present;
endmodule

// ==== rtl/dbd_dual_bus_demux.sv ====
// output side of the converter: demux onto two buses, forwarded clock,
// offset binary coding and the clocked internal reset sequencer
// assumes quant_code is produced on the sample clock by the comparator array,
// as a two's complement difference, one per sample edge
`timescale 1ns/10ps
module dbd_dual_bus_demux
   import dbd_pkg::*;
(
   // system clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // link clock: each rising edge stands for a falling sample clock edge
   input  wire logic                          sample_clk,
   input  wire logic [dbd_pkg::SAMPLE_W-1:0]  quant_code,
   // control pins
   input  wire logic                          edge_select_pin,
   input  wire logic                          power_down_pin,
   // output buses
   output dbd_pkg::dbd_word_pair_s            out_words,
   output logic                               out_bus_oe,
   output logic                               out_word_valid,
   // forwarded output clock pair
   output dbd_pkg::dbd_fwd_clk_s              out_clk,
   // analog section control and status
   output logic                               analog_power_down,
   output logic                               internal_reset_active,
   output logic                               clock_present
);
   import dbd_pkg::*;

   // ---------------- system clock domain ----------------

   dbd_ctl_s ctl_q;      // registered sequencer state
   dbd_ctl_s ctl_d;      // next sequencer state

   // link state is declared here because the clk side synchroniser reads it
   dbd_link_s lk_q;      // registered link state
   dbd_link_s lk_d;      // next link state

   logic [2:0] clk_sync; // synchronised into clk
   logic       pd_c;     // power down pin, clk domain
   logic       lrst_c;   // link internal reset, clk domain
   logic       alive_c;  // sample clock toggle, clk domain

   // pin and link levels cross into clk through two flops each
   dbd_sync #(
      .W (3)
   ) u_sync_clk (
      .clk      (clk),
      .async_in ({power_down_pin, lk_q.internal_reset, lk_q.alive_tgl}),
      .sync_out (clk_sync)
   );

   assign pd_c    = clk_sync[2];
   assign lrst_c  = clk_sync[1];
   assign alive_c = clk_sync[0];

   // watches the toggle so software-free status shows a running clock
   dbd_clk_mon u_clk_mon (
      .clk           (clk),
      .rst           (rst),
      .alive_s       (alive_c),
      .clock_present (clock_present)
   );

   // reset sequencer: request the link reset, see it taken, then release
   // and wait for the sample clock to count it out; with no sample clock
   // the handshake never completes and the analog section stays down
   always_comb begin
      ctl_d = ctl_q;
      unique case (ctl_q.seq)
         DBD_SEQ_ENTER: begin
            // hold the request until the link reports reset
            ctl_d.link_req = 1'b1;
            if (lrst_c) begin
               ctl_d.seq      = DBD_SEQ_RUNUP;
               ctl_d.link_req = 1'b0;
            end
         end
         DBD_SEQ_RUNUP: begin
            // link counts sample edges, then drops its reset
            ctl_d.link_req = 1'b0;
            if (!lrst_c) begin
               ctl_d.seq = DBD_SEQ_RUN;
            end
         end
         DBD_SEQ_RUN: begin
            ctl_d.link_req = 1'b0;
         end
         default: begin
            // illegal code: restart the sequence
            ctl_d.seq      = DBD_SEQ_ENTER;
            ctl_d.link_req = 1'b1;
         end
      endcase
      // analog held down through the whole reset sequence or by the pin
      ctl_d.reset_active = (ctl_d.seq != DBD_SEQ_RUN);
      ctl_d.analog_pd    = ctl_d.reset_active | pd_c;
   end

   // reset starts the sequence in its active state
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_q <= CTL_RST;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   assign analog_power_down     = ctl_q.analog_pd;
   assign internal_reset_active = ctl_q.reset_active;

   // ---------------- sample clock domain ----------------

   logic [2:0]          lk_sync;    // synchronised into sample_clk
   logic                req_l;      // reset request from the sequencer
   logic                edge_l;     // edge select pin, link domain
   logic                pd_l;       // power down pin, link domain
   logic [SAMPLE_W-1:0] code_ob;    // current result in offset binary

   // request and pins cross into the sample clock through two flops each
   dbd_sync #(
      .W (3)
   ) u_sync_link (
      .clk      (sample_clk),
      .async_in ({ctl_q.link_req, edge_select_pin, power_down_pin}),
      .sync_out (lk_sync)
   );

   assign req_l  = lk_sync[2];
   assign edge_l = lk_sync[1];
   assign pd_l   = lk_sync[0];

   // two's complement to offset binary: full positive -> all ones,
   // full negative -> all zeros, zero/-1 -> 128/127
   function automatic logic [SAMPLE_W-1:0] to_offset_binary(
      input logic [SAMPLE_W-1:0] twos
   );
      to_offset_binary = twos ^ OB_FLIP;
   endfunction

   assign code_ob = to_offset_binary(quant_code);

   // link datapath: odd edges park the result, even edges load both buses
   always_comb begin
      lk_d           = lk_q;
      // flips every edge so the clk side can tell the clock runs
      lk_d.alive_tgl = ~lk_q.alive_tgl;
      if (lk_q.internal_reset) begin
         // count out the reset; buses stay floating meanwhile
         lk_d.bus_oe = 1'b0;
         if (lk_q.seq_cnt == SEQ_LAST) begin
            lk_d.internal_reset = 1'b0;
         end else begin
            lk_d.seq_cnt = lk_q.seq_cnt + 1'b1;
         end
      end else if (pd_l) begin
         // power down: float, restart pairing, mark pipeline stale
         lk_d.bus_oe     = 1'b0;
         lk_d.parity     = 1'b0;
         lk_d.word_valid = 1'b0;
         lk_d.flush_cnt  = FLUSH_LOAD;
         // clock parks at its idle level so the next change is an edge
         lk_d.fwd.pos    = ~edge_l;
         lk_d.fwd.neg    = edge_l;
      end else begin
         lk_d.bus_oe = 1'b1;
         if (!lk_q.parity) begin
            // odd edge: park the result for the first bus
            lk_d.hold    = code_ob;
            lk_d.parity  = 1'b1;
            // move clock to the level opposite the data edge
            lk_d.fwd.pos = ~edge_l;
            lk_d.fwd.neg = edge_l;
         end else begin
            // even edge: both buses change in the same edge, whole words
            lk_d.words.first  = lk_q.hold;
            lk_d.words.second = code_ob;
            lk_d.parity       = 1'b0;
            // data change rides the rising edge when high, falling when low
            lk_d.fwd.pos      = edge_l;
            lk_d.fwd.neg      = ~edge_l;
            // first pairs after reset or power down carry stale contents
            lk_d.word_valid   = (lk_q.flush_cnt == '0);
            if (lk_q.flush_cnt != '0) begin
               lk_d.flush_cnt = lk_q.flush_cnt - 1'b1;
            end
         end
      end
   end

   // the request acts as a synchronous reset on the sample clock; a stopped
   // clock simply freezes everything, so the buses keep the last code
   always_ff @(posedge sample_clk) begin
      if (req_l) begin
         lk_q <= LINK_RST;
      end else begin
         lk_q <= lk_d;
      end
   end

   // all outputs toward the receiver come straight from link flops
   assign out_words      = lk_q.words;
   assign out_bus_oe     = lk_q.bus_oe;
   assign out_word_valid = lk_q.word_valid;
   assign out_clk        = lk_q.fwd;

endmodule

// ==== rtl/dbd_sync.sv ====
// two flip-flop level synchroniser, one bit per lane
// assumes each lane is a slow level or a toggle; words must not cross here
`timescale 1ns/10ps
module dbd_sync #(
   parameter int unsigned W = 1
) (
   // destination clock
   input  wire logic         clk,
   // asynchronous levels in
   input  wire logic [W-1:0] async_in,
   // synchronised levels out
   output logic      [W-1:0] sync_out
);
   // stage 0 feeds only stage 1; no reset so it also carries reset requests
   logic [1:0][W-1:0] st_q;
   logic [1:0][W-1:0] st_d;

   // shift one stage per edge
   always_comb begin
      st_d[0] = async_in;
      st_d[1] = st_q[0];
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign sync_out = st_q[1];
endmodule

// ==== shared/dbd_pkg.sv ====
// constants, state types and carriers for the dual bus output demux
// assumes one system clock (clk) and one sample clock on the link side
// What this block does
// - odd-edge results to first bus, even to second
// - each bus updates once per two sample edges
// - one forwarded clock pair times both buses
// - edge select picks data edge of clock
// - high: change on rising, low: on falling
// - offset binary coding, midscale toggles 127/128
// - clocked reset holds analog down until clock runs
// - hold code when stopped, float in power down while the sample clock runs
package dbd_pkg;

   // sample word width
   localparam int unsigned SAMPLE_W        = 8;
   // msb flip turns two's complement into offset binary
   localparam logic [SAMPLE_W-1:0] OB_FLIP = 8'h80;
   // code shown on the buses after reset
   localparam logic [SAMPLE_W-1:0] CODE_RST = 8'h00;

   // sample edges the internal reset stays active after its request drops
   localparam int unsigned RESET_SEQ_EDGES = 16;
   localparam int unsigned SEQ_CNT_W       = $clog2(RESET_SEQ_EDGES + 1);
   localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = SEQ_CNT_W'(RESET_SEQ_EDGES - 1);

   // word pairs marked stale after reset or power down exit
   localparam int unsigned FLUSH_WORDS     = 4;
   localparam int unsigned FLUSH_W         = $clog2(FLUSH_WORDS + 1);
   localparam logic [FLUSH_W-1:0] FLUSH_LOAD = FLUSH_W'(FLUSH_WORDS);

   // clk cycles without a sample clock toggle before it counts as stopped
   localparam int unsigned CLK_LOSS_CYCLES = 64;
   localparam int unsigned LOSS_W          = $clog2(CLK_LOSS_CYCLES + 1);
   localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(CLK_LOSS_CYCLES - 1);

   // reset sequencer states in the clk domain
   typedef enum logic [1:0] {
      DBD_SEQ_ENTER = 2'b00,   // request link reset, wait for it to be seen
      DBD_SEQ_RUNUP = 2'b01,   // request dropped, wait for link to finish
      DBD_SEQ_RUN   = 2'b10    // analog section powered
   } dbd_seq_e;

   // one word of each bus, first bus = odd edges
   typedef struct packed {
      logic [SAMPLE_W-1:0] first;
      logic [SAMPLE_W-1:0] second;
   } dbd_word_pair_s;

   // forwarded output clock pair
   typedef struct packed {
      logic pos;
      logic neg;
   } dbd_fwd_clk_s;

   // clk domain state
   typedef struct packed {
      dbd_seq_e seq;
      logic     link_req;
      logic     analog_pd;
      logic     reset_active;
   } dbd_ctl_s;

   // clock monitor state
   typedef struct packed {
      logic              last;
      logic [LOSS_W-1:0] cnt;
      logic              present;
   } dbd_mon_s;

   // sample clock domain state
   typedef struct packed {
      logic                 internal_reset;
      logic [SEQ_CNT_W-1:0] seq_cnt;
      logic                 parity;
      logic [SAMPLE_W-1:0]  hold;
      dbd_word_pair_s       words;
      logic                 bus_oe;
      logic                 word_valid;
      logic [FLUSH_W-1:0]   flush_cnt;
      dbd_fwd_clk_s         fwd;
      logic                 alive_tgl;
   } dbd_link_s;

   localparam dbd_ctl_s CTL_RST = '{seq: DBD_SEQ_ENTER, link_req: 1'b1,
                                    analog_pd: 1'b1, reset_active: 1'b1};
   localparam dbd_mon_s MON_RST = '{last: 1'b0, cnt: '0, present: 1'b0};
   localparam dbd_link_s LINK_RST = '{internal_reset: 1'b1, seq_cnt: '0,
                                      parity: 1'b0, hold: CODE_RST,
                                      words: '{first: CODE_RST, second: CODE_RST},
                                      bus_oe: 1'b0, word_valid: 1'b0,
                                      flush_cnt: FLUSH_LOAD,
                                      fwd: '{pos: 1'b0, neg: 1'b1}, alive_tgl: 1'b0};

endpackage
